/* File: seci_edge_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module seci_edge_flag (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic edge_seen,
  input  wire logic clear_pulse,
  output var  logic flag_q
);
  import seci_pkg::*;

  logic flag_d;

  // ****************************************
  // Sticky flag, set wins over clear
  // ****************************************
  always_comb begin
    flag_d = flag_q;
    if (clear_pulse) begin
      flag_d = 1'h0;
    end
    if (edge_seen) begin
      flag_d = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_q <= SECI_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  set_wins_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edge_seen |=> flag_q
  ) else $error("edge lost");

endmodule : seci_edge_flag
`default_nettype wire

/* File: seci_pkg.sv */
// Operation
// - Input low when pressed, high released
// - Pin pull-up enabled, initial output high
// - Optional polarity inversion after the pin
// - Separate rising and falling edge flags request interrupt
// - Writing one emits single clear pulse
// - Every bounce edge captured, no filtering
// - Pin edges may wake from low power
// - Debounce suspended in sleep, restarted after
package seci_pkg;

  // ****************************************
  // Reset values and clear write value
  // ****************************************
  localparam logic SECI_PIN_RELEASED  = 1'h1;
  localparam logic SECI_PULL_UP_ON    = 1'h1;
  localparam logic SECI_FLAG_RESET    = 1'h0;
  localparam logic SECI_CLEAR_PULSE_1 = 1'h1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic rise;
    logic fall;
  } seci_edges_t;

  typedef struct packed {
    logic invert;
    logic sleep;
    logic wake_enable;
  } seci_ctrl_t;

  typedef enum logic [1:0] {
    SECI_RUN     = 2'h0,
    SECI_ASLEEP  = 2'h1,
    SECI_RESTART = 2'h2
  } seci_power_t;

endpackage : seci_pkg

/* File: seci_switch_edge_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module seci_switch_edge_capture (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 switch_input,
  input  wire seci_pkg::seci_ctrl_t ctrl,
  input  wire logic                 clear_write,
  input  wire logic                 clear_wdata,
  output var  logic                 switch_level_q,
  output var  logic                 pin_pull_up_q,
  output var  logic                 pin_out_q,
  output var  logic                 edge_flag_clear_pulse,
  output var  logic                 rise_flag_q,
  output var  logic                 fall_flag_q,
  output var  logic                 edge_event_irq,
  output var  logic                 wake_q,
  output var  logic                 debounce_run_q
);
  import seci_pkg::*;

  // ****************************************
  // Pin and polarity
  // ****************************************
  logic        level_d;
  logic        prev_q;
  logic        prev_d;
  logic        pulse_d;
  logic        irq_d;
  logic        wake_d;
  logic        run_d;
  seci_edges_t edges;
  seci_power_t pwr_q;
  seci_power_t pwr_d;
  logic        rise_f;
  logic        fall_f;

  always_comb begin
    level_d = switch_input ^ ctrl.invert;
    prev_d  = level_d;
    edges.rise = level_d & ~prev_q;
    edges.fall = ~level_d & prev_q;
    pulse_d = clear_write & (clear_wdata == SECI_CLEAR_PULSE_1);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Follow the pin in reset, no false edge on release
      prev_q                <= level_d;
      switch_level_q        <= SECI_PIN_RELEASED;
      pin_pull_up_q         <= SECI_PULL_UP_ON;
      pin_out_q             <= SECI_PIN_RELEASED;
      edge_flag_clear_pulse <= 1'h0;
    end else begin
      prev_q                <= prev_d;
      switch_level_q        <= level_d;
      pin_pull_up_q         <= SECI_PULL_UP_ON;
      pin_out_q             <= SECI_PIN_RELEASED;
      edge_flag_clear_pulse <= pulse_d;
    end
  end

  // ****************************************
  // Edge flags
  // ****************************************
  seci_edge_flag u_rise (
    .clk         (clk),
    .reset_n     (reset_n),
    .edge_seen   (edges.rise),
    .clear_pulse (edge_flag_clear_pulse),
    .flag_q      (rise_f)
  );

  seci_edge_flag u_fall (
    .clk         (clk),
    .reset_n     (reset_n),
    .edge_seen   (edges.fall),
    .clear_pulse (edge_flag_clear_pulse),
    .flag_q      (fall_f)
  );

  // ****************************************
  // Interrupt and wake
  // ****************************************
  always_comb begin
    irq_d  = rise_f | fall_f;
    wake_d = ctrl.wake_enable & ctrl.sleep & (edges.rise | edges.fall);
    pwr_d  = pwr_q;
    run_d  = 1'h1;
    unique case (pwr_q)
      SECI_RUN: begin
        if (ctrl.sleep) begin
          pwr_d = SECI_ASLEEP;
        end
      end
      SECI_ASLEEP: begin
        run_d = 1'h0;
        if (!ctrl.sleep || wake_d) begin
          pwr_d = SECI_RESTART;
        end
      end
      SECI_RESTART: begin
        pwr_d = SECI_RUN;
      end
      default: begin
        pwr_d = SECI_RUN;
      end
    endcase
    if (pwr_d == SECI_ASLEEP) begin
      run_d = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rise_flag_q    <= SECI_FLAG_RESET;
      fall_flag_q    <= SECI_FLAG_RESET;
      edge_event_irq <= 1'h0;
      wake_q         <= 1'h0;
      debounce_run_q <= 1'h1;
      pwr_q          <= SECI_RUN;
    end else begin
      rise_flag_q    <= rise_f;
      fall_flag_q    <= fall_f;
      edge_event_irq <= irq_d;
      wake_q         <= wake_d;
      debounce_run_q <= run_d;
      pwr_q          <= pwr_d;
    end
  end

  // ****************************************
  // Capture checks
  // ****************************************
  rise_capture_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edges.rise |=> ##1 edge_event_irq
  ) else $error("rise not raised");

  fall_capture_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edges.fall |=> fall_f
  ) else $error("fall not caught");

  rise_flag_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edges.rise |=> ##1 rise_flag_q
  ) else $error("rise flag not shown");

  fall_flag_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edges.fall |=> ##1 fall_flag_q
  ) else $error("fall flag not shown");

  narrow_pulse_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edges.rise ##1 (edges.fall && !edge_flag_clear_pulse) |=> rise_f && fall_f
  ) else $error("narrow pulse lost");

  // ****************************************
  // Clear and interrupt checks
  // ****************************************
  clear_one_cycle_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edge_flag_clear_pulse |=> !edge_flag_clear_pulse || $past(pulse_d)
  ) else $error("pulse too long");

  clear_pulse_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pulse_d |=> edge_flag_clear_pulse
  ) else $error("clear pulse missing");

  no_stray_pulse_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !pulse_d |=> !edge_flag_clear_pulse
  ) else $error("stray clear pulse");

  clear_flags_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    edge_flag_clear_pulse && !edges.rise && !edges.fall |=> !rise_f && !fall_f
  ) else $error("flags not cleared");

  flag_sticky_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rise_f || fall_f) && !edge_flag_clear_pulse |=> rise_f || fall_f
  ) else $error("flag dropped");

  irq_or_flags_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rise_f | fall_f) |=> edge_event_irq
  ) else $error("irq missing");

  irq_cleared_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(rise_f || fall_f) |=> !edge_event_irq
  ) else $error("irq without flag");

  // ****************************************
  // Pin and power checks
  // ****************************************
  pull_up_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 (pin_pull_up_q && pin_out_q)
  ) else $error("pull up off");

  polarity_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    1'h1 |=> switch_level_q == ($past(switch_input) ^ $past(ctrl.invert))
  ) else $error("bad level");

  wake_edge_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wake_d |=> wake_q
  ) else $error("wake lost");

  wake_gated_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(ctrl.sleep && ctrl.wake_enable) |=> !wake_q
  ) else $error("wake while awake");

  sleep_stop_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pwr_q == SECI_ASLEEP) |=> !debounce_run_q || $past(pwr_d) != SECI_ASLEEP
  ) else $error("run in sleep");

  sleep_enter_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pwr_q == SECI_RUN) && ctrl.sleep |=> !debounce_run_q
  ) else $error("run after sleep entry");

  restart_run_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pwr_q == SECI_RESTART) |=> debounce_run_q
  ) else $error("no restart after wake");

endmodule : seci_switch_edge_capture
`default_nettype wire

/* File: seci_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Grounded push-button
// ****************
module seci_switch_model (
  input  wire logic pressed,
  output var  logic level
);
  // Shorts to ground, pull-up when open
  always_comb begin
    level = ~pressed;
  end
endmodule : seci_switch_model
`default_nettype wire

/* File: test_switch_edge_capture_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module test_switch_edge_capture_irq;
  import seci_pkg::*;
  logic       clk, reset_n, pressed, sw, cw, cd;
  seci_ctrl_t ctrl;
  logic       lvl, pu, po, pulse, rf, ff, irq, wake, run;
  int         num_errors = 0;
  int         n_compared = 0;
  int         event_count = 0;
  seci_switch_model sm (.pressed(pressed), .level(sw));
  seci_switch_edge_capture DUT (.clk(clk), .reset_n(reset_n), .switch_input(sw), .ctrl(ctrl),
    .clear_write(cw), .clear_wdata(cd), .switch_level_q(lvl), .pin_pull_up_q(pu), .pin_out_q(po),
    .edge_flag_clear_pulse(pulse), .rise_flag_q(rf), .fall_flag_q(ff), .edge_event_irq(irq),
    .wake_q(wake), .debounce_run_q(run));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // ****************
  // Helpers
  // ****************
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %b not %b", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 8 && s !== v; i++) begin
      cyc(1);
    end
    chk(s, v);
    if (s !== v) begin
      finish_test();
    end
  endtask : wt
  task automatic cnt(ref logic s, output int n);
    n = 0;
    repeat (5) begin
      n += (s === 1'h1);
      cyc(1);
    end
  endtask : cnt
  task automatic clr(input logic d, output int n);
    logic seen;
    seen = irq;
    cd = d;
    cw = 1'h1;
    cyc(1);
    cw = 1'h0;
    cnt(pulse, n);
    if (d && seen) begin
      event_count++;
    end
  endtask : clr
  // ****************
  // Scenarios
  // ****************
  task automatic t_press;
    int n;
    pressed = 1'h1;
    wt(irq, 1'h1);
    chk(ff, 1'h1);
    chk(rf, 1'h0);
    chk(lvl, 1'h0);
    clr(1'h0, n);
    chk(n == 0, 1'h1);
    chk(irq, 1'h1);
    clr(1'h1, n);
    chk(n == 1, 1'h1);
    chk(irq, 1'h0);
    chk(ff, 1'h0);
  endtask : t_press
  task automatic t_glitch;
    int n;
    pressed = 1'h0;
    cyc(1);
    pressed = 1'h1;
    wt(irq, 1'h1);
    cyc(2);
    chk(rf & ff, 1'h1);
    clr(1'h1, n);
    chk(irq, 1'h0);
  endtask : t_glitch
  task automatic t_invert;
    int n;
    ctrl.invert = 1'h1;
    cyc(3);
    clr(1'h1, n);
    pressed = 1'h0;
    wt(irq, 1'h1);
    chk(ff, 1'h1);
    chk(lvl, 1'h0);
    ctrl.invert = 1'h0;
    cyc(3);
    clr(1'h1, n);
  endtask : t_invert
  task automatic t_sleep;
    int n;
    ctrl.sleep = 1'h1;
    ctrl.wake_enable = 1'h1;
    wt(run, 1'h0);
    pressed = 1'h1;
    cnt(wake, n);
    chk(n == 1, 1'h1);
    ctrl.sleep = 1'h0;
    wt(run, 1'h1);
    clr(1'h1, n);
    chk(event_count == 5, 1'h1);
  endtask : t_sleep
  initial begin
    reset_n = 1'h0;
    pressed = 1'h0;
    ctrl = '0;
    cw = 1'h0;
    cd = 1'h0;
    cyc(12);
    reset_n = 1'h1;
    cyc(2);
    chk(pu & po, 1'h1);
    chk(irq, 1'h0);
    t_press();
    t_glitch();
    t_invert();
    t_sleep();
    finish_test();
  end
endmodule : test_switch_edge_capture_irq
`default_nettype wire
